// ---- shared/acc_defines.svh ----
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH

// ************************************************************
// Register offsets in the 10-bit data space
// ************************************************************
`define ACC_ADDR_W         10
`define ACC_ADDR_REF_LEVEL 10'h016   // Reference level select, write only
`define ACC_ADDR_RESULT    10'h017   // Comparison result, bit-test only
`define ACC_ADDR_ENABLE    10'h018   // Comparator enable and select, write only

// ************************************************************
// Field positions of the enable and select register
// ************************************************************
`define ACC_RUN_BIT        3         // Compare run
`define ACC_SRC_BIT        2         // Reference source, 1 = internal
`define ACC_SEL_HI         1         // Input select, high bit
`define ACC_SEL_LO         0         // Input select, low bit

// ************************************************************
// Reset values and timing counts
// ************************************************************
`define ACC_RST_ENABLE     4'h0
`define ACC_RST_REF_LEVEL  4'h0
`define ACC_RST_RESULT     4'h0
`define ACC_SYNC_STAGES    2         // Flip-flops on the comparator output

`endif

// ---- shared/acc_pkg.sv ----
package acc_pkg;

  // ************************************************************
  // Power modes seen by the comparator
  // ************************************************************
  typedef enum logic [1:0] {
    ACC_PWR_ACTIVE    = 2'b00,  // Active mode
    ACC_PWR_SUBACTIVE = 2'b01,  // Subactive mode
    ACC_PWR_STANDBY   = 2'b10,  // Standby, comparator off
    ACC_PWR_STOP      = 2'b11   // Stop, comparator off
  } acc_pwr_e;

  // ************************************************************
  // Comparison state
  // ************************************************************
  typedef enum logic {
    ACC_CMP_IDLE = 1'b0,        // No comparison
    ACC_CMP_RUN  = 1'b1         // Comparison in progress
  } acc_state_e;

  // ************************************************************
  // Enable and select register layout
  // ************************************************************
  typedef struct packed {
    logic       run;            // Compare run bit
    logic       ref_src;        // Reference source bit, 1 = internal
    logic [1:0] in_sel;         // Analog input select
  } acc_ctrl_s;

  // ************************************************************
  // Controls to the analog front end
  // ************************************************************
  typedef struct packed {
    logic       enable;         // Comparator powered and comparing
    logic       int_ref_sw;     // Internal reference switch closed
    logic [3:0] ref_level;      // One of sixteen internal levels
    logic [1:0] in_sel;         // Analog input multiplexer select
  } acc_afe_s;

endpackage : acc_pkg

// ---- verilog/acc_sync.sv ----
`timescale 1ns/1ps

// ************************************************************
// Two-stage level synchroniser
// ************************************************************
module acc_sync (
  input  wire logic i_clk_sys,   // System clock
  input  wire logic i_rst_n,     // Asynchronous reset, active low
  input  wire logic i_async,     // Level from outside the clock domain
  output logic      o_sync       // Synchronised level
);

  logic meta_ff;                 // First stage, read only by second
  logic sync_ff;                 // Second stage
  logic nxt_meta;
  logic nxt_sync;

  // Next values of the two stages
  always_comb begin
    nxt_meta = i_async;
    nxt_sync = meta_ff;
  end

  // Stage registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign o_sync = sync_ff;

endmodule : acc_sync

// ---- verilog/acc_top.sv ----
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_top (
  input  wire logic              i_clk_sys,          // Instruction clock, 20 MHz
  input  wire logic              i_rst_n,            // MCU reset, active low
  input  wire logic              i_reg_wr,           // Register write strobe
  input  wire logic [9:0]        i_reg_addr,         // Register write address
  input  wire logic [3:0]        i_reg_wdata,        // Register write data
  input  wire logic              i_bt_req,           // Bit-test instruction strobe
  input  wire logic [9:0]        i_bt_addr,          // Bit-test address
  input  wire logic [1:0]        i_bt_bit,           // Bit-test bit number
  input  wire acc_pkg::acc_pwr_e i_power_mode,       // Current power mode
  input  wire logic              i_cmp_out,          // Raw analog comparator output
  output logic                   o_test_result_flag, // Test flag answer
  output logic                   o_bt_hit,           // Bit test addressed the result
  output acc_pkg::acc_afe_s      o_afe,              // Front-end controls
  output logic [3:0]             o_port_disable,     // Analog pins off as ports
  output logic                   o_ext_ref_pin_disable // Reference pin off as port
);
  import acc_pkg::*;

  // ************************************************************
  // Storage
  // ************************************************************
  acc_ctrl_s  ctrl_ff;           // Enable and select register
  logic [3:0] ref_level_ff;      // Reference level register
  logic [3:0] result_ff;         // Comparison result register
  acc_state_e state_ff;          // Comparison state
  acc_afe_s   afe_ff;            // Registered front-end controls
  logic [3:0] port_dis_ff;       // Registered analog pin disables
  logic       ext_dis_ff;        // Registered reference pin disable
  logic       flag_ff;           // Registered test flag
  logic       hit_ff;            // Registered bit-test hit

  acc_ctrl_s  nxt_ctrl;
  logic [3:0] nxt_ref_level;
  logic [3:0] nxt_result;
  acc_state_e nxt_state;
  acc_afe_s   nxt_afe;
  logic [3:0] nxt_port_dis;
  logic       nxt_ext_dis;
  logic       nxt_flag;
  logic       nxt_hit;

  logic       cmp_sync;          // Comparator output after two flip-flops
  logic       mode_ok;           // Power mode allows comparing
  logic [3:0] sel_mask;          // One-hot of the selected input

  // ************************************************************
  // Comparator output synchroniser
  // ************************************************************
  acc_sync u_cmp_sync (
    .i_clk_sys (i_clk_sys),
    .i_rst_n   (i_rst_n),
    .i_async   (i_cmp_out),
    .o_sync    (cmp_sync)
  );

  // Power mode gate and input mask
  always_comb begin
    mode_ok  = (i_power_mode == ACC_PWR_ACTIVE) || (i_power_mode == ACC_PWR_SUBACTIVE);
    sel_mask = 4'h1 << ctrl_ff.in_sel;
  end

  // ************************************************************
  // Register writes
  // ************************************************************
  // Address decode of the two write-only registers
  always_comb begin
    nxt_ctrl      = ctrl_ff;
    nxt_ref_level = ref_level_ff;
    if (i_reg_wr && (i_reg_addr == `ACC_ADDR_ENABLE)) begin
      nxt_ctrl.run     = i_reg_wdata[`ACC_RUN_BIT];
      nxt_ctrl.ref_src = i_reg_wdata[`ACC_SRC_BIT];
      nxt_ctrl.in_sel  = i_reg_wdata[`ACC_SEL_HI:`ACC_SEL_LO];
    end else if (i_reg_wr && (i_reg_addr == `ACC_ADDR_REF_LEVEL)) begin
      nxt_ref_level = i_reg_wdata;
    end
  end

  // ************************************************************
  // Comparison control and result
  // ************************************************************
  // Run state, front-end controls and pin functions
  always_comb begin
    // Comparing only while the run bit is set in a working mode
    nxt_state = (ctrl_ff.run && mode_ok) ? ACC_CMP_RUN : ACC_CMP_IDLE;
    nxt_afe.enable     = (nxt_state == ACC_CMP_RUN);
    nxt_afe.int_ref_sw = (nxt_state == ACC_CMP_RUN) && ctrl_ff.ref_src;
    nxt_afe.ref_level  = ref_level_ff;
    nxt_afe.in_sel     = ctrl_ff.in_sel;
    nxt_port_dis       = (nxt_state == ACC_CMP_RUN) ? 4'hF : 4'h0;
    nxt_ext_dis        = !ctrl_ff.ref_src;
  end

  // Result bits, one per input, only the selected one is filled
  always_comb begin
    if (state_ff == ACC_CMP_RUN) begin
      nxt_result = sel_mask & {4{cmp_sync}};
    end else begin
      nxt_result = `ACC_RST_RESULT;
    end
  end

  // ************************************************************
  // Bit-test read path
  // ************************************************************
  // The result is only visible through the bit-test answer
  always_comb begin
    nxt_hit  = i_bt_req && (i_bt_addr == `ACC_ADDR_RESULT);
    nxt_flag = flag_ff;
    if (nxt_hit) begin
      nxt_flag = result_ff[i_bt_bit];
    end
  end

  // All state registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_ff      <= acc_ctrl_s'(`ACC_RST_ENABLE);
      ref_level_ff <= `ACC_RST_REF_LEVEL;
      result_ff    <= `ACC_RST_RESULT;
      state_ff     <= ACC_CMP_IDLE;
      afe_ff       <= '0;
      port_dis_ff  <= 4'h0;
      ext_dis_ff   <= 1'b1;
      flag_ff      <= 1'b0;
      hit_ff       <= 1'b0;
    end else begin
      ctrl_ff      <= nxt_ctrl;
      ref_level_ff <= nxt_ref_level;
      result_ff    <= nxt_result;
      state_ff     <= nxt_state;
      afe_ff       <= nxt_afe;
      port_dis_ff  <= nxt_port_dis;
      ext_dis_ff   <= nxt_ext_dis;
      flag_ff      <= nxt_flag;
      hit_ff       <= nxt_hit;
    end
  end

  // Outputs, all from flip-flops
  assign o_test_result_flag    = flag_ff;
  assign o_bt_hit              = hit_ff;
  assign o_afe                 = afe_ff;
  assign o_port_disable        = port_dis_ff;
  assign o_ext_ref_pin_disable = ext_dis_ff;

  // ************************************************************
  // Assertions
  // ************************************************************
  run_start_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (ctrl_ff.run && mode_ok) |=> (state_ff == ACC_CMP_RUN) && o_afe.enable)
    else $error("Comparison did not start after run bit");

  flag_high_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_bt_req && (i_bt_addr == `ACC_ADDR_RESULT) && result_ff[i_bt_bit]) |=> o_test_result_flag && o_bt_hit)
    else $error("Test flag not set for a high result");

  flag_low_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_bt_req && (i_bt_addr == `ACC_ADDR_RESULT) && !result_ff[i_bt_bit]) |=> !o_test_result_flag)
    else $error("Test flag not cleared for a low result");

  result_onehot_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (result_ff & ~(4'h1 << afe_ff.in_sel)) == 4'h0)
    else $error("Result bit set for an unselected input");

  result_clear_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_ff == ACC_CMP_RUN) ##1 (state_ff == ACC_CMP_IDLE) |=> (result_ff == 4'h0))
    else $error("Result kept after comparison ended");

  ref_level_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_reg_wr && (i_reg_addr == `ACC_ADDR_REF_LEVEL)) |-> ##2 (o_afe.ref_level == $past(i_reg_wdata, 2)))
    else $error("Reference level not passed to front end");

  int_switch_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    o_afe.int_ref_sw |-> $past(ctrl_ff.ref_src) && $past(ctrl_ff.run))
    else $error("Internal switch closed without internal source");

  pins_analog_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_ff == ACC_CMP_RUN) |-> (o_port_disable == 4'hF))
    else $error("Analog pins kept port function while comparing");

  mode_gate_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !mode_ok |=> (state_ff == ACC_CMP_IDLE) && !o_afe.enable && !o_afe.int_ref_sw)
    else $error("Comparator active in a stopped mode");

  ext_ref_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !ctrl_ff.ref_src |=> o_ext_ref_pin_disable)
    else $error("Reference pin still a port with external source");

  result_update_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (state_ff == ACC_CMP_RUN) |=> (result_ff[$past(ctrl_ff.in_sel)] == $past(cmp_sync)))
    else $error("Result not updated from comparator");

endmodule : acc_top

// ---- sim/acc_top_test.sv ----
`timescale 1ns/1ps
`include "acc_defines.svh"

module acc_top_test;
  import acc_pkg::*;

  // ************************************************************
  // Stimulus and observation signals
  // ************************************************************
  logic              i_clk_sys;             // Instruction clock
  logic              i_rst_n;               // Reset, active low
  logic              i_reg_wr;              // Register write strobe
  logic [9:0]        i_reg_addr;            // Register write address
  logic [3:0]        i_reg_wdata;           // Register write data
  logic              i_bt_req;              // Bit-test strobe
  logic [9:0]        i_bt_addr;             // Bit-test address
  logic [1:0]        i_bt_bit;              // Bit-test bit number
  acc_pwr_e          i_power_mode;          // Power mode
  logic              i_cmp_out;             // Raw comparator level
  logic              o_test_result_flag;    // Test flag answer
  logic              o_bt_hit;              // Bit test hit the result
  acc_afe_s          o_afe;                 // Front-end controls
  logic [3:0]        o_port_disable;        // Analog pins off as ports
  logic              o_ext_ref_pin_disable; // Reference pin off as port
  int                failures;              // Mismatch count
  int                n_tests;               // Comparison count
  int                cycles;                // Watchdog cycle count
  integer            seed;                  // Random seed
  logic              last_flag;             // Flag expected to persist

  acc_top u_acc_top (
    .i_clk_sys            (i_clk_sys),
    .i_rst_n              (i_rst_n),
    .i_reg_wr             (i_reg_wr),
    .i_reg_addr           (i_reg_addr),
    .i_reg_wdata          (i_reg_wdata),
    .i_bt_req             (i_bt_req),
    .i_bt_addr            (i_bt_addr),
    .i_bt_bit             (i_bt_bit),
    .i_power_mode         (i_power_mode),
    .i_cmp_out            (i_cmp_out),
    .o_test_result_flag   (o_test_result_flag),
    .o_bt_hit             (o_bt_hit),
    .o_afe                (o_afe),
    .o_port_disable       (o_port_disable),
    .o_ext_ref_pin_disable(o_ext_ref_pin_disable)
  );

  // ************************************************************
  // Clock and watchdog
  // ************************************************************
  // 20 MHz clock, 25 ns half period
  initial begin
    i_clk_sys = 1'b0;
    forever #25 i_clk_sys = ~i_clk_sys;
  end

  // Cuts a hang short well above the expected run length
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // Shared tasks
  // ************************************************************
  // Compares one value and reports a mismatch at once
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One register write, strobe held for one edge
  task automatic wr(input logic [9:0] addr, input logic [3:0] data);
    @(negedge i_clk_sys);
    i_reg_wr    = 1'b1;
    i_reg_addr  = addr;
    i_reg_wdata = data;
    @(negedge i_clk_sys);
    i_reg_wr    = 1'b0;
  endtask : wr

  // One bit test; answer is looked at one edge after the request
  task automatic bt(input logic [9:0] addr, input logic [1:0] bitn, input logic hit, input logic flag);
    @(negedge i_clk_sys);
    i_bt_req  = 1'b1;
    i_bt_addr = addr;
    i_bt_bit  = bitn;
    @(negedge i_clk_sys);
    i_bt_req  = 1'b0;
    chk("bit test hit", {7'h00, hit}, {7'h00, o_bt_hit});
    chk("test flag", {7'h00, flag}, {7'h00, o_test_result_flag});
    last_flag = flag;
  endtask : bt

  // Comparator runs only with run set in active or subactive mode
  function automatic logic running(input logic [3:0] ctl, input acc_pwr_e md);
    return ctl[`ACC_RUN_BIT] && (md == ACC_PWR_ACTIVE || md == ACC_PWR_SUBACTIVE);
  endfunction : running

  // Sets mode, level, enable and comparator, then checks every output
  task automatic trial(input acc_pwr_e md, input logic [3:0] ctl, input logic [3:0] lvl, input logic cmp);
    logic on;
    on = running(ctl, md);
    i_power_mode = md;
    wr(`ACC_ADDR_REF_LEVEL, lvl);
    wr(`ACC_ADDR_ENABLE, ctl);
    wr(10'h019, ~ctl);
    i_cmp_out = cmp;
    repeat (6) @(negedge i_clk_sys);
    chk("afe enable", {7'h00, on}, {7'h00, o_afe.enable});
    chk("int ref switch", {7'h00, on & ctl[`ACC_SRC_BIT]}, {7'h00, o_afe.int_ref_sw});
    chk("ref level", {4'h0, lvl}, {4'h0, o_afe.ref_level});
    chk("input select", {6'h00, ctl[1:0]}, {6'h00, o_afe.in_sel});
    chk("port disable", {4'h0, {4{on}}}, {4'h0, o_port_disable});
    chk("ref pin disable", {7'h00, ~ctl[`ACC_SRC_BIT]}, {7'h00, o_ext_ref_pin_disable});
    for (int b = 0; b < 4; b++) begin
      bt(`ACC_ADDR_RESULT, b[1:0], 1'b1, on && (b[1:0] == ctl[1:0]) && cmp);
    end
    bt(`ACC_ADDR_ENABLE, ctl[1:0], 1'b0, last_flag);
  endtask : trial

  // Prints the counts and the verdict, then ends the run
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : tally_and_finish

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [3:0] ctl;
    logic [3:0] lvl;
    acc_pwr_e   md;
    seed = 32'h3cb2;
    failures = 0;
    n_tests = 0;
    cycles = 0;
    last_flag = 1'b0;
    i_rst_n = 1'b0;
    i_reg_wr = 1'b0;
    i_reg_addr = 10'h000;
    i_reg_wdata = 4'h0;
    i_bt_req = 1'b0;
    i_bt_addr = 10'h000;
    i_bt_bit = 2'h0;
    i_power_mode = ACC_PWR_ACTIVE;
    i_cmp_out = 1'b0;
    repeat (20) @(negedge i_clk_sys);
    // Reset values while reset is still held
    chk("reset afe", 8'h00, o_afe);
    chk("reset port disable", 8'h00, {4'h0, o_port_disable});
    chk("reset ref pin", 8'h01, {7'h00, o_ext_ref_pin_disable});
    chk("reset flag", 8'h00, {7'h00, o_test_result_flag});
    i_rst_n = 1'b1;
    // Corner cases: extreme levels, then run dropped, then mode gating
    trial(ACC_PWR_ACTIVE, 4'b1111, 4'hF, 1'b1);
    // Mid-run reset must clear the result, the front-end controls and the test flag
    i_rst_n = 1'b0;
    repeat (2) @(negedge i_clk_sys);
    chk("mid reset afe", 8'h00, o_afe);
    chk("mid reset flag", 8'h00, {7'h00, o_test_result_flag});
    i_rst_n = 1'b1;
    bt(`ACC_ADDR_RESULT, 2'h3, 1'b1, 1'b0);
    trial(ACC_PWR_ACTIVE, 4'b0111, 4'hF, 1'b1);
    trial(ACC_PWR_SUBACTIVE, 4'b1000, 4'h0, 1'b1);
    trial(ACC_PWR_SUBACTIVE, 4'b1000, 4'h0, 1'b0);
    trial(ACC_PWR_STANDBY, 4'b1101, 4'h5, 1'b1);
    trial(ACC_PWR_STOP, 4'b1110, 4'hA, 1'b1);
    // Random mix of modes, selects, sources and levels
    for (int i = 0; i < 40; i++) begin
      ctl = 4'($random(seed));
      lvl = 4'($random(seed));
      md  = ($random(seed) % 3 == 0) ? acc_pwr_e'(2'($random(seed))) : ACC_PWR_ACTIVE;
      trial(md, ctl | {($random(seed) % 4 != 0), 3'b000}, lvl, 1'($random(seed)));
    end
    tally_and_finish();
  end

endmodule : acc_top_test
